/* File: hw/scv_gate.sv */
// Purpose: security-code verification and write gating of the memory card
// Assumes: the memory core does the actual erase/write and read timing
// Notes: error counter and code are held here; sys_rst stands for power-up
`timescale 1ns/100ps
module scv_gate
    import scv_pkg::*;
#(
    parameter logic [15:0] CODE_INIT = CODE_RESET,
    parameter logic [7:0] ERR_INIT = ERR_FULL
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic card_clk,
    input wire logic dir_cmd,
    input wire logic io_in,
    output logic io_out,
    output logic io_oe,
    input wire logic prot_bit,
    output logic mem_go,
    output logic mem_deny,
    output logic [5:0] mem_ctl,
    output logic [scv_pkg::ADDR_W-1:0] mem_addr,
    output logic [7:0] mem_data,
    output logic read_hide,
    output logic verified,
    output logic [7:0] err_count
);
    // ****************************************
    // command capture
    // ****************************************
    logic card_rise;
    logic cmd_start;
    logic cmd_done;
    logic [CMD_BITS-1:0] cmd_bits;

    scv_cmd_shift #(
        .BITS(CMD_BITS)
    ) u_shift (
        .clk(clk),
        .sys_rst(sys_rst),
        .card_clk(card_clk),
        .dir_cmd(dir_cmd),
        .io_in(io_in),
        .card_rise(card_rise),
        .cmd_start(cmd_start),
        .cmd_done(cmd_done),
        .cmd_bits(cmd_bits)
    );

    // ****************************************
    // decode
    // ****************************************
    function automatic logic is_code_addr(input logic [ADDR_W-1:0] a);
        is_code_addr = (a == ADDR_CODE_LO) || (a == ADDR_CODE_HI);
    endfunction

    wire [5:0] ctl_w = cmd_bits[CTL_LSB +: 6];
    wire [ADDR_W-1:0] addr_w = {cmd_bits[A9_POS], cmd_bits[A8_POS], cmd_bits[ALO_LSB +: 8]};
    wire [7:0] data_w = cmd_bits[DATA_LSB +: 8];
    wire is_write_w = (ctl_w == CTL_WR_PROT) || (ctl_w == CTL_WR_PLAIN) || (ctl_w == CTL_PROT_CMP);
    wire is_read_w = (ctl_w == CTL_RD_PROT) || (ctl_w == CTL_RD_PLAIN);
    wire is_err_mod_w = (ctl_w == CTL_ERR_MOD) && (addr_w == ADDR_ERR);
    wire is_cmp_w = (ctl_w == CTL_CODE_CMP) && is_code_addr(addr_w);
    // erasing the counter is a plain erase/write aimed at the counter byte
    wire is_err_erase_w = (ctl_w == CTL_WR_PLAIN) && (addr_w == ADDR_ERR);

    logic verified_reg;
    logic [7:0] err_reg;
    logic [15:0] code_reg;
    logic armed_reg;
    logic lo_ok_reg;
    logic hi_ok_reg;

    // the mask selects the one counter bit to clear; it must still be set
    wire [7:0] err_clear_w = err_reg & data_w;
    wire one_bit_w = (err_clear_w != 8'h00) && ((err_clear_w & (err_clear_w - 8'h01)) == 8'h00);
    wire [7:0] code_byte_w = addr_w[0] ? code_reg[15:8] : code_reg[7:0];
    // an empty counter can never unlock, whatever bytes were entered
    wire attempt_ok_w = armed_reg && lo_ok_reg && hi_ok_reg && (err_reg != ERR_EMPTY);
    wire pass_w = verified_reg || attempt_ok_w;
    wire write_ok_w = verified_reg && prot_bit && !is_err_erase_w;
    wire code_wr_w = write_ok_w && is_code_addr(addr_w) && (ctl_w != CTL_PROT_CMP);
    wire hide_w = is_read_w && !verified_reg && is_code_addr(addr_w);

    // ****************************************
    // security state
    // ****************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            verified_reg <= 1'b0;
            err_reg <= ERR_INIT;
            code_reg <= CODE_INIT;
            armed_reg <= 1'b0;
            lo_ok_reg <= 1'b0;
            hi_ok_reg <= 1'b0;
        end else if (cmd_done) begin
            if (is_err_mod_w && one_bit_w) begin
                err_reg <= err_reg & ~data_w;
                armed_reg <= 1'b1;
                lo_ok_reg <= 1'b0;
                hi_ok_reg <= 1'b0;
            end else if (is_cmp_w && armed_reg) begin
                if (addr_w == ADDR_CODE_LO) begin
                    lo_ok_reg <= (data_w == code_byte_w);
                end else begin
                    hi_ok_reg <= lo_ok_reg && (data_w == code_byte_w);
                end
            end else if (is_err_erase_w) begin
                armed_reg <= 1'b0;
                lo_ok_reg <= 1'b0;
                hi_ok_reg <= 1'b0;
                if (pass_w) begin
                    verified_reg <= 1'b1;
                    err_reg <= ERR_FULL;
                end
            end else if (code_wr_w) begin
                if (addr_w[0]) begin
                    code_reg[15:8] <= data_w;
                end else begin
                    code_reg[7:0] <= data_w;
                end
            end
        end
    end

    // ****************************************
    // data-line answer to the counter erase
    // ****************************************
    scv_state_t state_reg;
    scv_state_t state_next;
    logic [CNT_W-1:0] edge_reg;
    logic [CNT_W-1:0] target_reg;
    wire hit_w = card_rise && ((edge_reg + 7'h01) == target_reg);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SCV_IDLE: begin
                if (cmd_done && is_err_erase_w) begin
                    state_next = SCV_WAIT;
                end
            end
            SCV_WAIT: begin
                if (cmd_start) begin
                    state_next = SCV_IDLE;
                end else if (hit_w) begin
                    state_next = SCV_PULL;
                end
            end
            SCV_PULL: begin
                // line stays low until the reader starts a new command
                if (cmd_start) begin
                    state_next = SCV_IDLE;
                end
            end
            default: state_next = SCV_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= SCV_IDLE;
            edge_reg <= '0;
            target_reg <= FAIL_EDGES;
        end else begin
            state_reg <= state_next;
            if (state_reg == SCV_IDLE) begin
                edge_reg <= '0;
                target_reg <= pass_w ? PASS_EDGES : FAIL_EDGES;
            end else if (card_rise && state_reg == SCV_WAIT) begin
                edge_reg <= edge_reg + 7'h01;
            end
        end
    end

    // ****************************************
    // outputs, all registered
    // ****************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            io_out <= 1'b0;
            io_oe <= 1'b0;
            mem_go <= 1'b0;
            mem_deny <= 1'b0;
            mem_ctl <= '0;
            mem_addr <= '0;
            mem_data <= '0;
            read_hide <= 1'b0;
            verified <= 1'b0;
            err_count <= ERR_INIT;
        end else begin
            io_out <= 1'b0;
            io_oe <= (state_next == SCV_PULL) && !dir_cmd;
            mem_go <= cmd_done && (is_read_w || (is_write_w && write_ok_w));
            mem_deny <= cmd_done && is_write_w && !write_ok_w;
            if (cmd_done) begin
                mem_ctl <= ctl_w;
                mem_addr <= addr_w;
                mem_data <= data_w;
                read_hide <= hide_w;
            end
            verified <= verified_reg;
            err_count <= err_reg;
        end
    end
endmodule

/* File: hw/scv_pkg.sv */
// Purpose: shared constants of the security-code verification block
// Assumes: commands arrive as 24 serial bits, first bit in bit 0
// Notes: control codes are written as {s5..s0}
package scv_pkg;
    localparam int CMD_BITS = 24;
    localparam int ADDR_W = 10;
    localparam int CNT_W = 7;
    // control codes, {s5,s4,s3,s2,s1,s0}
    localparam logic [5:0] CTL_WR_PROT = 6'h31;
    localparam logic [5:0] CTL_WR_PLAIN = 6'h33;
    localparam logic [5:0] CTL_PROT_CMP = 6'h30;
    localparam logic [5:0] CTL_RD_PROT = 6'h0C;
    localparam logic [5:0] CTL_RD_PLAIN = 6'h0E;
    localparam logic [5:0] CTL_ERR_MOD = 6'h32;
    localparam logic [5:0] CTL_CODE_CMP = 6'h0D;
    // field positions inside the shifted command
    localparam int CTL_LSB = 0;
    localparam int A8_POS = 6;
    localparam int A9_POS = 7;
    localparam int ALO_LSB = 8;
    localparam int DATA_LSB = 16;
    // special addresses
    localparam logic [ADDR_W-1:0] ADDR_ERR = 10'h3FD;
    localparam logic [ADDR_W-1:0] ADDR_CODE_LO = 10'h3FE;
    localparam logic [ADDR_W-1:0] ADDR_CODE_HI = 10'h3FF;
    // card clock rises from command end to the data-line answer
    localparam logic [CNT_W-1:0] FAIL_EDGES = 7'h03;
    localparam logic [CNT_W-1:0] PASS_EDGES = 7'h67;
    localparam logic [7:0] ERR_FULL = 8'hFF;
    localparam logic [7:0] ERR_EMPTY = 8'h00;
    localparam logic [15:0] CODE_RESET = 16'hFFFF;
    typedef enum logic [2:0] {
        SCV_IDLE = 3'b001,
        SCV_WAIT = 3'b010,
        SCV_PULL = 3'b100
    } scv_state_t;
endpackage

/* File: hw/scv_cmd_shift.sv */
// Purpose: collects the 24 serial command bits from the card reader
// Assumes: card clock, direction line and data line are synchronous samples
// Notes: a command ends when the direction line falls
`timescale 1ns/100ps
module scv_cmd_shift
    import scv_pkg::*;
#(
    parameter int BITS = CMD_BITS
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic card_clk,
    input wire logic dir_cmd,
    input wire logic io_in,
    output logic card_rise,
    output logic cmd_start,
    output logic cmd_done,
    output logic [BITS-1:0] cmd_bits
);
    logic clk_d_reg;
    logic dir_d_reg;
    logic [BITS-1:0] shift_reg;
    wire rise_w = card_clk & ~clk_d_reg;

    assign card_rise = rise_w;
    assign cmd_start = dir_cmd & ~dir_d_reg;
    assign cmd_done = ~dir_cmd & dir_d_reg;
    assign cmd_bits = shift_reg;

    // bits enter at the top and walk down, so the first bit lands in bit 0
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            clk_d_reg <= 1'b0;
            dir_d_reg <= 1'b0;
            shift_reg <= '0;
        end else begin
            clk_d_reg <= card_clk;
            dir_d_reg <= dir_cmd;
            if (dir_cmd && rise_w) begin
                shift_reg <= {io_in, shift_reg[BITS-1:1]};
            end
        end
    end
endmodule

/* File: verification/scv_gate_properties.sv */
// Purpose: port-level timing checks of the verification gate
// Assumes: one clock, synchronous reset
// Notes: bound to every scv_gate
`timescale 1ns/100ps
module scv_gate_properties
    import scv_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic card_clk,
    input wire logic dir_cmd,
    input wire logic io_in,
    input wire logic io_out,
    input wire logic io_oe,
    input wire logic prot_bit,
    input wire logic mem_go,
    input wire logic mem_deny,
    input wire logic [5:0] mem_ctl,
    input wire logic [scv_pkg::ADDR_W-1:0] mem_addr,
    input wire logic [7:0] mem_data,
    input wire logic read_hide,
    input wire logic verified,
    input wire logic [7:0] err_count
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire wr_cmd = mem_ctl == CTL_WR_PROT || mem_ctl == CTL_WR_PLAIN || mem_ctl == CTL_PROT_CMP;
    a_pulse_excl: assert property (!(mem_go && mem_deny)) else $error("go and deny together");
    a_go_once: assert property (mem_go |=> !mem_go) else $error("go held too long");
    a_deny_once: assert property (mem_deny |=> !mem_deny) else $error("deny held too long");
    a_locked_write: assert property (mem_go && wr_cmd |-> verified) else $error("write passed while locked");
    a_hide_locked: assert property (read_hide |-> !verified) else $error("hidden read while verified");
    a_oe_release: assert property (io_oe && dir_cmd |=> !io_oe) else $error("data line not released");
    a_open_drain: assert property (io_out == 1'b0) else $error("data line driven high");
    a_count_step: assert property (!$stable(err_count) |->
        err_count == ERR_FULL || $countones($past(err_count) ^ err_count) == 1) else $error("counter jump");
    a_answer_state: assert property ($rose(io_oe) |-> verified == (err_count == ERR_FULL))
        else $error("answer disagrees with state");
    a_empty_locked: assert property (err_count == ERR_EMPTY && !verified |=> !verified)
        else $error("unlocked with empty counter");
endmodule
bind scv_gate scv_gate_properties u_props(.clk(clk), .sys_rst(sys_rst), .card_clk(card_clk), .dir_cmd(dir_cmd),
    .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .prot_bit(prot_bit), .mem_go(mem_go), .mem_deny(mem_deny),
    .mem_ctl(mem_ctl), .mem_addr(mem_addr), .mem_data(mem_data), .read_hide(read_hide), .verified(verified),
    .err_count(err_count));

/* File: verification/scv_reader.sv */
// Purpose: card reader model driving the three-wire link
// Assumes: card clock 2 clk high, 2 clk low, pulsed outside frames only through rise
// Notes: data line released to the pull-up between commands
`timescale 1ns/100ps
module scv_reader (
    input wire logic clk,
    output logic card_clk,
    output logic dir_cmd,
    output logic io_drv
);
    initial begin
        card_clk = 1'b0;
        dir_cmd = 1'b0;
        io_drv = 1'b1;
    end
    // one card clock pulse; the clock stands at 0 afterwards
    task automatic rise();
        @(posedge clk) card_clk <= 1'b1;
        repeat (2) @(posedge clk);
        card_clk <= 1'b0;
        @(posedge clk);
    endtask
    // bit 0 goes out first, so each byte travels lsb first
    task automatic send(input logic [23:0] c);
        @(posedge clk) dir_cmd <= 1'b1;
        for (int i = 0; i < 24; i++) begin
            io_drv <= c[i];
            rise();
        end
        dir_cmd <= 1'b0;
        io_drv <= 1'b1;
        @(posedge clk);
    endtask
endmodule

/* File: verification/security_code_verification_tb_top.sv */
// Purpose: self-checking bench of the verification gate
// Assumes: reader model drives the link, bench model tracks state
// Notes: each reset reloads the code from CODE_INIT, here CODE0
`timescale 1ns/100ps
module security_code_verification_tb_top;
    import scv_pkg::*;
    localparam logic [15:0] CODE0 = 16'h5AC3;
    logic clk, sys_rst, prot_bit, g, d, m_ver;
    logic io_out, io_oe, mem_go, mem_deny, read_hide, verified;
    logic [5:0] mem_ctl;
    logic [5:0] wr [3] = '{CTL_WR_PROT, CTL_WR_PLAIN, CTL_PROT_CMP};
    logic [ADDR_W-1:0] mem_addr, a;
    logic [7:0] mem_data, err_count, m_err, x;
    wire card_clk, dir_cmd, io_drv;
    // open-drain line with pull-up
    wire io_line = io_drv && !io_oe;
    int errors = 0;
    int tests_run = 0;
    integer seed = 32'hEE3C9FB0;
    scv_reader rd(.clk(clk), .card_clk(card_clk), .dir_cmd(dir_cmd), .io_drv(io_drv));
    scv_gate #(.CODE_INIT(CODE0), .ERR_INIT(ERR_FULL)) dut(.clk(clk), .sys_rst(sys_rst), .card_clk(card_clk),
        .dir_cmd(dir_cmd), .io_in(io_line), .io_out(io_out), .io_oe(io_oe), .prot_bit(prot_bit), .mem_go(mem_go),
        .mem_deny(mem_deny), .mem_ctl(mem_ctl), .mem_addr(mem_addr), .mem_data(mem_data), .read_hide(read_hide),
        .verified(verified), .err_count(err_count));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task end_sim();
        if (errors == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task cmd(input logic [5:0] c, input logic [ADDR_W-1:0] ad, input logic [7:0] dt);
        rd.send({dt, ad[7:0], ad[9], ad[8], c});
        g = 1'b0;
        d = 1'b0;
        repeat (4) begin
            @(negedge clk);
            g |= mem_go;
            d |= mem_deny;
        end
    endtask
    // full attempt; a pass answers late, a failure early
    task attempt(input logic [7:0] mask, input logic [15:0] key);
        logic pass;
        pass = m_ver || (key == CODE0 && (m_err & ~mask) != 0);
        cmd(CTL_ERR_MOD, ADDR_ERR, mask);
        m_err = m_err & ~mask;
        check(err_count, m_err);
        cmd(CTL_CODE_CMP, ADDR_CODE_LO, key[7:0]);
        cmd(CTL_CODE_CMP, ADDR_CODE_HI, key[15:8]);
        cmd(CTL_WR_PLAIN, ADDR_ERR, ERR_FULL);
        for (int k = 1; k <= (pass ? 103 : 3); k++) begin
            rd.rise();
            check({io_out, io_line}, {1'b0, k < (pass ? 103 : 3)});
        end
        if (pass) begin
            m_err = ERR_FULL;
            m_ver = 1'b1;
        end
        check({verified, err_count}, {m_ver, m_err});
    endtask
    initial begin
        sys_rst = 1'b1;
        prot_bit = 1'b1;
        m_err = ERR_FULL;
        m_ver = 1'b0;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        foreach (wr[i]) begin
            cmd(wr[i], 10'h005, 8'h00);
            check({g, d}, 2'b01);
        end
        cmd(CTL_RD_PLAIN, ADDR_CODE_LO, 8'h00);
        check({g, d, read_hide}, 3'b101);
        cmd(CTL_RD_PROT, 10'h010, 8'h00);
        check({g, read_hide}, 2'b10);
        attempt(8'h01, ~CODE0);
        attempt(8'h02, CODE0);
        for (int i = 0; i < 4; i++) begin
            a = 10'($unsigned($random(seed)) % 1000);
            x = 8'($random(seed));
            @(posedge clk) prot_bit <= i[0];
            cmd(wr[i % 3], a, x);
            check({g, d, mem_ctl, mem_addr, mem_data}, {i[0], !i[0], wr[i % 3], a, x});
        end
        // power-up again: state must be lost
        @(posedge clk) sys_rst <= 1'b1;
        @(posedge clk) sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        m_err = ERR_FULL;
        m_ver = 1'b0;
        check({verified, err_count}, {1'b0, ERR_FULL});
        attempt(8'h80, CODE0);
        x = 8'($random(seed));
        cmd(CTL_WR_PLAIN, ADDR_CODE_LO, x);
        check({g, d}, 2'b10);
        // once verified, a code location reads back like any other byte
        cmd(CTL_RD_PLAIN, ADDR_CODE_HI, 8'h00);
        check({g, d, read_hide}, 3'b100);
        // power-up again: burn all eight bits, then even the right code must fail
        @(posedge clk) sys_rst <= 1'b1;
        @(posedge clk) sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        m_err = ERR_FULL;
        m_ver = 1'b0;
        for (int j = 0; j < 8; j++) begin
            attempt(8'h01 << j, ~CODE0);
        end
        attempt(8'h01, CODE0);
        check({verified, err_count}, {1'b0, ERR_EMPTY});
        end_sim();
    end
    initial begin
        #400000;
        errors++;
        end_sim();
    end
endmodule
